// file: logic/sba_top.sv
// software-driven two-wire bus master with its four configuration registers
// Behaviour
// - read byte lands in data register
// - index byte addresses inside the target
// - target address write launches one cycle
// - target address resets to A0h
// - bits 7:1 give the target address
// - bit 0 selects write or read
// - control bit 7 omits the index byte
// - control bit 6 reads zero
// - busy bit 5 tracks a cycle
// - bit 4 tracks the EEPROM download
// - reset clears data, index and control
// - bit 1 flags a failed cycle
// - bit 0 flags an EEPROM load error
// - bit 3 flags EEPROM present, enables bus
`default_nettype none
`timescale 1ns/100ps
module sba_top (
  input  wire logic                     CLK,
  input  wire logic                     RESET,
  input  wire sba_pkg::sba_cfg_req_type CFG_REQ,
  output logic [7:0]                    CFG_RDATA,
  input  wire logic                     EEPROM_STRAP,
  input  wire logic                     ROM_LOAD_BUSY,
  input  wire logic                     ROM_LOAD_ERR,
  input  wire logic                     SCL_IN,
  output logic                          SCL_OUT,
  output logic                          SCL_OE_N,
  input  wire logic                     SDA_IN,
  output logic                          SDA_OUT,
  output logic                          SDA_OE_N
);
  sba_pkg::sba_main_type r_reg;
  sba_pkg::sba_main_type r_next;
  logic                  eng_done;
  logic [7:0]            eng_rx;
  logic                  eng_nack;
  logic                  launch;
  logic                  fail;

  sba_bit_engine u_eng (
    .clk      (CLK),
    .reset    (RESET),
    .cmd_valid(r_reg.cmd_valid),
    .cmd      (r_reg.cmd),
    .tx_byte  (r_reg.tx),
    .done     (eng_done),
    .rx_byte  (eng_rx),
    .nack     (eng_nack),
    .scl_in   (SCL_IN),
    .sda_in   (SDA_IN),
    .scl_oe_n (SCL_OE_N),
    .sda_oe_n (SDA_OE_N),
    .pin_lvl  (SDA_OUT)
  );

  // both pins only ever pull low
  assign SCL_OUT = SDA_OUT;

  always_comb begin
    r_next = r_reg;
    r_next.cmd_valid = 1'b0;
    fail = 1'b0;
    r_next.rom_busy = ROM_LOAD_BUSY;
    // strap caught once after reset release
    if (!r_reg.strap_done) begin
      r_next.strap_done = 1'b1;
      r_next.present = EEPROM_STRAP;
    end
    if (CFG_REQ.rd) begin
      case (CFG_REQ.addr)
        sba_pkg::DATA_OFS:   r_next.rdata = r_reg.data;
        sba_pkg::INDEX_OFS:  r_next.rdata = r_reg.index;
        sba_pkg::TARGET_OFS: r_next.rdata = r_reg.target;
        sba_pkg::CS_OFS:     r_next.rdata = {r_reg.mode, 1'b0, r_reg.busy, r_reg.rom_busy,
                                             r_reg.present, 1'b0, r_reg.cyc_err, r_reg.rom_err};
        default:             r_next.rdata = 8'h00;
      endcase
    end
    // launch only from idle, never during download
    launch = CFG_REQ.wr && CFG_REQ.addr == sba_pkg::TARGET_OFS && !r_reg.busy && !r_reg.rom_busy;
    if (CFG_REQ.wr) begin
      case (CFG_REQ.addr)
        // index held for the next cycle
        sba_pkg::DATA_OFS:  r_next.data = CFG_REQ.wdata;
        sba_pkg::INDEX_OFS: r_next.index = CFG_REQ.wdata;
        sba_pkg::TARGET_OFS: begin
          if (!r_reg.busy) begin
            r_next.target = CFG_REQ.wdata;
          end
        end
        sba_pkg::CS_OFS: begin
          r_next.mode = CFG_REQ.wdata[sba_pkg::CS_MODE_BIT];
          r_next.present = CFG_REQ.wdata[sba_pkg::CS_PRESENT_BIT];
          if (CFG_REQ.wdata[sba_pkg::CS_CYCERR_BIT]) begin
            r_next.cyc_err = 1'b0;
          end
          if (CFG_REQ.wdata[sba_pkg::CS_ROMERR_BIT]) begin
            r_next.rom_err = 1'b0;
          end
        end
        default: r_next.data = r_reg.data;
      endcase
    end
    // load error sticks, set beats clear
    if (ROM_LOAD_ERR) begin
      r_next.rom_err = 1'b1;
    end
    if (launch) begin
      if (r_reg.present) begin
        r_next.busy = 1'b1;
        r_next.st = sba_pkg::SBA_START;
        r_next.cmd_valid = 1'b1;
        r_next.cmd = sba_pkg::SBA_CMD_START;
      end else begin
        // without an enabled interface the cycle fails at once
        r_next.cyc_err = 1'b1;
      end
    end
    case (r_reg.st)
      sba_pkg::SBA_IDLE: r_next.st = r_next.st;
      sba_pkg::SBA_START: begin
        if (eng_done) begin
          r_next.st = sba_pkg::SBA_ADDR;
          r_next.cmd_valid = 1'b1;
          r_next.cmd = sba_pkg::SBA_CMD_WRITE;
          // direction bit sent when no index precedes
          r_next.tx = {r_reg.target[7:1], r_reg.mode ? r_reg.target[0] : 1'b0};
        end
      end
      sba_pkg::SBA_ADDR: begin
        if (eng_done) begin
          r_next.cmd_valid = 1'b1;
          if (eng_nack) begin
            fail = 1'b1;
          // index byte only in mode 0
          end else if (!r_reg.mode) begin
            r_next.st = sba_pkg::SBA_INDEX;
            r_next.cmd = sba_pkg::SBA_CMD_WRITE;
            r_next.tx = r_reg.index;
          end else begin
            r_next.st = sba_pkg::SBA_XFER;
            r_next.cmd = r_reg.target[0] ? sba_pkg::SBA_CMD_READ : sba_pkg::SBA_CMD_WRITE;
            r_next.tx = r_reg.data;
          end
        end
      end
      sba_pkg::SBA_INDEX: begin
        if (eng_done) begin
          r_next.cmd_valid = 1'b1;
          if (eng_nack) begin
            fail = 1'b1;
          end else if (r_reg.target[0]) begin
            r_next.st = sba_pkg::SBA_RSTART;
            r_next.cmd = sba_pkg::SBA_CMD_START;
          end else begin
            // data register already holds the byte
            r_next.st = sba_pkg::SBA_XFER;
            r_next.cmd = sba_pkg::SBA_CMD_WRITE;
            r_next.tx = r_reg.data;
          end
        end
      end
      sba_pkg::SBA_RSTART: begin
        if (eng_done) begin
          r_next.st = sba_pkg::SBA_ADDR_R;
          r_next.cmd_valid = 1'b1;
          r_next.cmd = sba_pkg::SBA_CMD_WRITE;
          r_next.tx = {r_reg.target[7:1], 1'b1};
        end
      end
      sba_pkg::SBA_ADDR_R: begin
        if (eng_done) begin
          r_next.cmd_valid = 1'b1;
          if (eng_nack) begin
            fail = 1'b1;
          end else begin
            r_next.st = sba_pkg::SBA_XFER;
            r_next.cmd = sba_pkg::SBA_CMD_READ;
          end
        end
      end
      sba_pkg::SBA_XFER: begin
        if (eng_done) begin
          r_next.st = sba_pkg::SBA_STOP;
          r_next.cmd_valid = 1'b1;
          r_next.cmd = sba_pkg::SBA_CMD_STOP;
          if (r_reg.target[0]) begin
            // received byte stored before busy drops
            r_next.data = eng_rx;
          end else if (eng_nack) begin
            r_next.cyc_err = 1'b1;
          end
        end
      end
      sba_pkg::SBA_STOP: begin
        if (eng_done) begin
          r_next.st = sba_pkg::SBA_IDLE;
          r_next.busy = 1'b0;
        end
      end
      default: r_next.st = sba_pkg::SBA_IDLE;
    endcase
    // missing acknowledge ends with stop and error
    if (fail) begin
      r_next.cyc_err = 1'b1;
      r_next.st = sba_pkg::SBA_STOP;
      r_next.cmd = sba_pkg::SBA_CMD_STOP;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      r_reg <= sba_pkg::MAIN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign CFG_RDATA = r_reg.rdata;

  reset_target_a: assert property (@(posedge CLK) disable iff (RESET)
    $fell(RESET) |-> r_reg.target == sba_pkg::TARGET_RST && r_reg.data == sba_pkg::DATA_RST
    && !r_reg.busy)
    else $error("target address not at default after reset");
  launch_busy_a: assert property (@(posedge CLK) disable iff (RESET)
    (CFG_REQ.wr && CFG_REQ.addr == sba_pkg::TARGET_OFS && !r_reg.busy && !r_reg.rom_busy
    && r_reg.present)
    |=> r_reg.busy && r_reg.st == sba_pkg::SBA_START && r_reg.cmd_valid)
    else $error("launch did not start a cycle");
  rsvd_read_a: assert property (@(posedge CLK) disable iff (RESET)
    (CFG_REQ.rd && CFG_REQ.addr == sba_pkg::CS_OFS) |=> !CFG_RDATA[6] && !CFG_RDATA[2]
    && CFG_RDATA[5] == $past(r_reg.busy))
    else $error("control read shows wrong reserved or busy bits");
  nack_error_a: assert property (@(posedge CLK) disable iff (RESET)
    (eng_done && eng_nack && r_reg.st == sba_pkg::SBA_ADDR) |=> r_reg.cyc_err
    && r_reg.st == sba_pkg::SBA_STOP)
    else $error("address nack did not flag an error");
  err_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    (CFG_REQ.wr && CFG_REQ.addr == sba_pkg::CS_OFS && CFG_REQ.wdata[sba_pkg::CS_CYCERR_BIT]
    && !fail && !launch
    && !(eng_done && r_reg.st == sba_pkg::SBA_XFER)) |=> !r_reg.cyc_err)
    else $error("cycle error not cleared by write of one");
  rom_err_a: assert property (@(posedge CLK) disable iff (RESET)
    ROM_LOAD_ERR |=> r_reg.rom_err)
    else $error("load error lost");
  read_data_a: assert property (@(posedge CLK) disable iff (RESET)
    (eng_done && r_reg.st == sba_pkg::SBA_XFER && r_reg.target[0])
    |=> r_reg.data == $past(eng_rx) && r_reg.busy)
    else $error("read byte not stored");
  index_skip_a: assert property (@(posedge CLK) disable iff (RESET)
    (eng_done && !eng_nack && r_reg.st == sba_pkg::SBA_ADDR)
    |=> r_reg.st == ($past(r_reg.mode) ? sba_pkg::SBA_XFER : sba_pkg::SBA_INDEX))
    else $error("index byte sent against address mode");
  addr_byte_a: assert property (@(posedge CLK) disable iff (RESET)
    (r_reg.st == sba_pkg::SBA_ADDR && r_reg.cmd_valid)
    |-> r_reg.tx == {r_reg.target[7:1], $past(r_reg.mode) & r_reg.target[0]})
    else $error("address byte wrong");
  busy_end_a: assert property (@(posedge CLK) disable iff (RESET)
    (eng_done && r_reg.st == sba_pkg::SBA_STOP)
    |=> !r_reg.busy ##1 (!r_reg.busy || $past(launch)))
    else $error("busy not cleared after stop");
endmodule // sba_top
`default_nettype wire

// file: logic/sba_pkg.sv
// shared constants and types for the software serial bus access block
`default_nettype none
package sba_pkg;
  // register byte offsets in configuration space
  localparam logic [7:0] DATA_OFS   = 8'hB0;
  localparam logic [7:0] INDEX_OFS  = 8'hB1;
  localparam logic [7:0] TARGET_OFS = 8'hB2;
  localparam logic [7:0] CS_OFS     = 8'hB3;
  // control/status field positions
  localparam int CS_MODE_BIT    = 7;
  localparam int CS_RSVD6_BIT   = 6;
  localparam int CS_BUSY_BIT    = 5;
  localparam int CS_EEPROM_LOAD_BUSY_FLAG_BIT = 4;
  localparam int CS_PRESENT_BIT = 3;
  localparam int CS_RSVD2_BIT   = 2;
  localparam int CS_CYCERR_BIT  = 1;
  localparam int CS_ROMERR_BIT  = 0;
  // reset values
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] INDEX_RST  = 8'h00;
  localparam logic [7:0] TARGET_RST = 8'hA0;
  localparam logic [7:0] CS_RST     = 8'h00;
  // serial clock timing: a quarter of a 100 kHz bit, least time so rounded up
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int QTR_CYC        = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);

  typedef enum logic [1:0] {
    SBA_CMD_START = 2'h0,
    SBA_CMD_STOP  = 2'h1,
    SBA_CMD_WRITE = 2'h2,
    SBA_CMD_READ  = 2'h3
  } sba_cmd_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sba_cfg_req_type;

  typedef enum logic [7:0] {
    SBA_IDLE   = 8'h01,
    SBA_START  = 8'h02,
    SBA_ADDR   = 8'h04,
    SBA_INDEX  = 8'h08,
    SBA_RSTART = 8'h10,
    SBA_ADDR_R = 8'h20,
    SBA_XFER   = 8'h40,
    SBA_STOP   = 8'h80
  } sba_main_state_type;

  typedef struct packed {
    sba_main_state_type st;
    logic [7:0]         data;
    logic [7:0]         index;
    logic [7:0]         target;
    logic               mode;
    logic               present;
    logic               strap_done;
    logic               cyc_err;
    logic               rom_err;
    logic               busy;
    logic               rom_busy;
    logic               cmd_valid;
    sba_cmd_type        cmd;
    logic [7:0]         tx;
    logic [7:0]         rdata;
  } sba_main_type;

  localparam sba_main_type MAIN_RST = '{
    st: SBA_IDLE, data: DATA_RST, index: INDEX_RST, target: TARGET_RST,
    mode: CS_RST[CS_MODE_BIT], present: CS_RST[CS_PRESENT_BIT], strap_done: 1'b0,
    cyc_err: CS_RST[CS_CYCERR_BIT], rom_err: CS_RST[CS_ROMERR_BIT],
    busy: CS_RST[CS_BUSY_BIT], rom_busy: CS_RST[CS_EEPROM_LOAD_BUSY_FLAG_BIT], cmd_valid: 1'b0,
    cmd: SBA_CMD_START, tx: 8'h00, rdata: 8'h00};

  typedef enum logic [1:0] {
    SBA_ENG_IDLE = 2'b01,
    SBA_ENG_RUN  = 2'b10
  } sba_eng_state_type;

  typedef struct packed {
    sba_eng_state_type st;
    logic [8:0]        div;
    logic [1:0]        qtr;
    logic [3:0]        bits;
    sba_cmd_type       cmd;
    logic [8:0]        shift;
    logic [7:0]        rx;
    logic              nack;
    logic              done;
    logic              scl;
    logic              sda;
    logic              lvl;
  } sba_eng_type;

  localparam sba_eng_type ENG_RST = '{
    st: SBA_ENG_IDLE, div: 9'h000, qtr: 2'h0, bits: 4'h0, cmd: SBA_CMD_START,
    shift: 9'h1FF, rx: 8'h00, nack: 1'b0, done: 1'b0, scl: 1'b1, sda: 1'b1, lvl: 1'b0};
endpackage
`default_nettype wire

// file: logic/sba_bit_engine.sv
// two-wire bit engine: start, stop, byte write and byte read
`default_nettype none
`timescale 1ns/100ps
module sba_bit_engine (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              cmd_valid,
  input  wire sba_pkg::sba_cmd_type cmd,
  input  wire logic [7:0]        tx_byte,
  output logic                   done,
  output logic [7:0]             rx_byte,
  output logic                   nack,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   scl_oe_n,
  output logic                   sda_oe_n,
  output logic                   pin_lvl
);
  sba_pkg::sba_eng_type r_reg;
  sba_pkg::sba_eng_type r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    case (r_reg.st)
      sba_pkg::SBA_ENG_IDLE: begin
        r_next.div = 9'h000;
        r_next.qtr = 2'h0;
        if (cmd_valid) begin
          r_next.st = sba_pkg::SBA_ENG_RUN;
          r_next.cmd = cmd;
          r_next.bits = 4'h0;
          // reads release data for all bits and answer with a not-acknowledge
          r_next.shift = (cmd == sba_pkg::SBA_CMD_WRITE) ? {tx_byte, 1'b1} : 9'h1FF;
        end
      end
      sba_pkg::SBA_ENG_RUN: begin
        // a target holding the clock low stretches the high phase
        if (r_reg.qtr == 2'h2 && !scl_in) begin
          r_next.div = 9'h000;
        end else if (r_reg.div != sba_pkg::QTR_LAST) begin
          r_next.div = r_reg.div + 9'h001;
        end else begin
          r_next.div = 9'h000;
          r_next.qtr = r_reg.qtr + 2'h1;
          case (r_reg.cmd)
            sba_pkg::SBA_CMD_START: begin
              case (r_reg.qtr)
                2'h0: r_next.sda = 1'b1;
                2'h1: r_next.scl = 1'b1;
                2'h2: r_next.sda = 1'b0;
                default: begin
                  r_next.scl = 1'b0;
                  r_next.st = sba_pkg::SBA_ENG_IDLE;
                  r_next.done = 1'b1;
                end
              endcase
            end
            sba_pkg::SBA_CMD_STOP: begin
              case (r_reg.qtr)
                2'h0: r_next.sda = 1'b0;
                2'h1: r_next.scl = 1'b1;
                2'h2: r_next.sda = 1'b1;
                default: begin
                  r_next.st = sba_pkg::SBA_ENG_IDLE;
                  r_next.done = 1'b1;
                end
              endcase
            end
            default: begin
              case (r_reg.qtr)
                2'h0: r_next.sda = r_reg.shift[8];
                2'h1: r_next.scl = 1'b1;
                2'h2: begin
                  if (r_reg.bits == 4'h8) begin
                    r_next.nack = sda_in;
                  end else begin
                    r_next.rx = {r_reg.rx[6:0], sda_in};
                  end
                end
                default: begin
                  r_next.scl = 1'b0;
                  r_next.shift = {r_reg.shift[7:0], 1'b1};
                  r_next.bits = r_reg.bits + 4'h1;
                  if (r_reg.bits == 4'h8) begin
                    r_next.sda = 1'b1;
                    r_next.st = sba_pkg::SBA_ENG_IDLE;
                    r_next.done = 1'b1;
                  end
                end
              endcase
            end
          endcase
        end
      end
      default: r_next = sba_pkg::ENG_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= sba_pkg::ENG_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done     = r_reg.done;
  assign rx_byte  = r_reg.rx;
  assign nack     = r_reg.nack;
  assign scl_oe_n = r_reg.scl;
  assign sda_oe_n = r_reg.sda;
  assign pin_lvl  = r_reg.lvl;
endmodule // sba_bit_engine
`default_nettype wire

// file: verif/sba_eeprom_model.sv
// behavioural two-wire serial EEPROM with byte pointer, pull-ups assumed on both lines
`default_nettype none
`timescale 1ns/100ps
module sba_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic scl,
  input  wire logic sda,
  output var logic  sda_low
);
  logic [7:0] mem [256];
  logic [7:0] ptr;
  logic [7:0] sh;
  int         bitn;
  logic       act;
  logic       rdmode;
  logic       first;
  logic       addrd;

  initial begin
    sda_low = 1'b0;
    act     = 1'b0;
    ptr     = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5C;
  end

  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1; bitn = -1; addrd = 1'b1; rdmode = 1'b0; sda_low = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;

  always @(posedge scl) if (act && !rdmode && bitn < 8) sh = {sh[6:0], sda};

  // ack, pointer load, write and read data, msb first
  always @(negedge scl) if (act) begin
    bitn = bitn + 1;
    if (bitn == 8) begin
      if (rdmode) sda_low = 1'b0;
      else if (addrd && sh[7:1] != DEV_ADDR) act = 1'b0;
      else begin
        sda_low = 1'b1;
        if (addrd) begin
          rdmode = sh[0];
          first  = !sh[0];
        end else if (first) begin
          ptr = sh; first = 1'b0;
        end else begin
          mem[ptr] = sh; ptr++;
        end
        addrd = 1'b0;
      end
    end else if (bitn == 9) begin
      bitn = 0; sda_low = 1'b0;
      // a master not-acknowledge ends the read, so the line stays free for stop
      if (rdmode && sda) act = 1'b0;
      else if (rdmode) begin
        sh = mem[ptr]; ptr++; sda_low = !sh[7];
      end
    end else if (rdmode) sda_low = !sh[7-bitn];
  end
endmodule // sba_eeprom_model
`default_nettype wire

// file: verif/serial_bus_sw_access_tb.sv
// self-checking bench for the software serial bus access block
`default_nettype none
`timescale 1ns/100ps
module serial_bus_sw_access_tb;
  localparam int LIMIT = 95000;
  logic                     clk;
  logic                     reset;
  sba_pkg::sba_cfg_req_type req;
  logic [7:0]               rdata;
  logic                     rom_busy;
  logic                     rom_err;
  logic                     scl_oe_n;
  logic                     sda_oe_n;
  logic                     sda_low;
  wire logic                scl_w;
  wire logic                sda_w;
  int                       n_errors;
  int                       n_tests;
  int                       cycles;
  logic                     strap;
  logic                     scl_out;
  logic                     sda_out;

  // pull-ups: a released line reads high
  assign scl_w = scl_oe_n;
  assign sda_w = sda_oe_n & ~sda_low;

  sba_top i_dut (
    .CLK          (clk),
    .RESET        (reset),
    .CFG_REQ      (req),
    .CFG_RDATA    (rdata),
    .EEPROM_STRAP (strap),
    .ROM_LOAD_BUSY(rom_busy),
    .ROM_LOAD_ERR (rom_err),
    .SCL_IN       (scl_w),
    .SCL_OUT      (scl_out),
    .SCL_OE_N     (scl_oe_n),
    .SDA_IN       (sda_w),
    .SDA_OUT      (sda_out),
    .SDA_OE_N     (sda_oe_n)
  );

  sba_eeprom_model i_mem (
    .scl    (scl_w),
    .sda    (sda_w),
    .sda_low(sda_low)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    bus_rd(a, v);
    chk(v, exp);
  endtask

  // bounded poll of the cycle busy flag
  task automatic wait_idle();
    logic [7:0] v;
    for (int i = 0; i < 30000; i++) begin
      bus_rd(8'hB3, v);
      if (v[5] === 1'b0) break;
    end
    chk(v & 8'h20, 8'h00); // busy ends in time
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic reset_vals(input logic [7:0] cs_exp);
    rd_chk(8'hB0, 8'h00); // data cleared
    rd_chk(8'hB1, 8'h00); // index cleared
    rd_chk(8'hB2, 8'hA0); // target default
    rd_chk(8'hB3, cs_exp); // control cleared, strap caught
    rd_chk(8'hB4, 8'h00); // unmapped offset reads zero
    chk({4'h0, scl_oe_n, sda_oe_n, scl_out, sda_out}, 8'h0C); // lines released
  endtask

  initial begin
    req = '0;
    reset = 1'b1;
    rom_busy = 1'b0;
    rom_err = 1'b0;
    strap = 1'b1;
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    do_reset();
    reset_vals(8'h08);
    $display("test reset values done");

    // read-only and reserved bits ignore writes
    bus_wr(8'hB3, 8'h7E);
    rd_chk(8'hB3, 8'h08); // bits 6,5,4,2 stay zero
    @(posedge clk);
    rom_busy <= 1'b1;
    bus_wr(8'hB2, 8'hA2);
    rd_chk(8'hB3, 8'h18); // download busy shown, no launch
    rd_chk(8'hB2, 8'hA2); // address stored though not launched
    @(posedge clk);
    rom_busy <= 1'b0;
    rom_err <= 1'b1;
    @(posedge clk);
    rom_err <= 1'b0;
    rd_chk(8'hB3, 8'h09); // load error latched
    bus_wr(8'hB3, 8'h09);
    rd_chk(8'hB3, 8'h08); // write one clears
    $display("test status bits done");

    // indexed single byte write
    bus_wr(8'hB0, 8'h5A);
    bus_wr(8'hB1, 8'h35);
    bus_wr(8'hB2, 8'hA0);
    rd_chk(8'hB3, 8'h28); // busy during cycle
    wait_idle();
    rd_chk(8'hB3, 8'h08); // busy cleared, no error
    chk(i_mem.mem[8'h35], 8'h5A);
    rd_chk(8'hB2, 8'hA0); // address field readback
    $display("test indexed write done");

    // address-only read continues from the pointer after the write
    bus_wr(8'hB3, 8'h88);
    bus_wr(8'hB2, 8'hA1);
    wait_idle();
    rd_chk(8'hB0, 8'h36 ^ 8'h5C);
    rd_chk(8'hB3, 8'h88); // mode kept, no error
    $display("test address-only read done");

    // nobody answers at this address
    bus_wr(8'hB2, 8'hA3);
    wait_idle();
    rd_chk(8'hB3, 8'h8A); // missing ack flagged
    bus_wr(8'hB3, 8'h8A);
    rd_chk(8'hB3, 8'h88); // write one clears
    bus_wr(8'hB3, 8'h00);
    bus_wr(8'hB2, 8'hA0);
    rd_chk(8'hB3, 8'h02); // no present flag, launch fails
    $display("test errors done");

    // second reset in mid-run, strap now showing no EEPROM
    bus_wr(8'hB1, 8'h77);
    bus_wr(8'hB3, 8'h80);
    bus_wr(8'hB2, 8'hA3);
    strap <= 1'b0;
    do_reset();
    reset_vals(8'h00);
    @(posedge clk);
    strap <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(8'hB3, 8'h00); // strap caught only once
    $display("test second reset done");
    conclude();
  end
endmodule // serial_bus_sw_access_tb
`default_nettype wire
